// File: hdl/uraf_bit_voter.sv
`default_nettype none

module uraf_bit_voter (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RESET,
    // Sample timing
    input  wire logic RESTART,
    input  wire logic TICK,
    input  wire logic DOUBLE_SPEED,
    // Line and decision
    input  wire logic RXD,
    output logic      VOTE_DONE,
    output logic      VOTE_BIT
);
    import uraf_pkg::*;

    logic [4:0] samp_cnt_ff;
    logic [4:0] nxt_samp;
    logic [4:0] spb;
    logic [4:0] first_s;
    logic [4:0] mid_s;
    logic       v_first_ff;
    logic       v_mid_ff;
    logic       vote_done_ff;
    logic       vote_bit_ff;

    assign spb     = DOUBLE_SPEED ? SPB_DOUBLE : SPB_NORMAL;      // [RULE_03]
    assign first_s = DOUBLE_SPEED ? FIRST_DOUBLE : FIRST_NORMAL;  // [RULE_04]
    assign mid_s   = DOUBLE_SPEED ? MID_DOUBLE : MID_NORMAL;      // [RULE_05]

    always_comb begin
        if (RESTART || samp_cnt_ff == spb) begin
            nxt_samp = 5'h01;
        end else begin
            nxt_samp = samp_cnt_ff + 5'h01;
        end
    end

    // Sample 1 is the first low sample after the falling edge
    always_ff @(posedge CLK) begin
        if (RESET) begin
            samp_cnt_ff <= 5'h00;
        end else if (TICK) begin
            samp_cnt_ff <= nxt_samp;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            v_first_ff   <= 1'b1;
            v_mid_ff     <= 1'b1;
            vote_done_ff <= 1'b0;
            vote_bit_ff  <= 1'b1;
        end else begin
            vote_done_ff <= 1'b0;
            if (TICK && nxt_samp == first_s) begin
                v_first_ff <= RXD;
            end
            if (TICK && nxt_samp == mid_s) begin
                v_mid_ff <= RXD;
            end
            if (TICK && nxt_samp == first_s + 5'h02) begin
                vote_done_ff <= 1'b1;
                vote_bit_ff  <= (v_first_ff & v_mid_ff) | (v_first_ff & RXD) | (v_mid_ff & RXD); // [RULE_22]
            end
        end
    end

    assign VOTE_DONE = vote_done_ff;
    assign VOTE_BIT  = vote_bit_ff;

endmodule : uraf_bit_voter

`default_nettype wire

// File: hdl/uraf_pkg.sv
`default_nettype none

package uraf_pkg;

    // ==========================================================
    // Register map (byte addresses, one word each)
    // ==========================================================
    localparam logic [7:0] ADDR_DATA   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_FORMAT = 8'h0C;
    localparam logic [7:0] ADDR_BAUD   = 8'h10;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int ST_RX_COMPLETE   = 7;
    localparam int ST_TX_COMPLETE   = 6;
    localparam int ST_TX_EMPTY      = 5;
    localparam int ST_FRAMING_ERR   = 4;
    localparam int ST_OVERRUN       = 3;
    localparam int ST_PARITY_ERR    = 2;
    localparam int ST_DOUBLE_SPEED  = 1;
    localparam int ST_ADDR_FILTER   = 0;
    localparam int CT_RX_ENABLE     = 4;
    localparam int CT_TX_ENABLE     = 3;
    localparam int CT_CHAR_SIZE_HI  = 2;
    localparam int CT_RX_NINTH      = 1;
    localparam int CT_TX_NINTH      = 0;
    localparam int FM_PARITY_LO     = 4;
    localparam int FM_STOP_BITS     = 3;
    localparam int FM_CHAR_SIZE_LO  = 1;

    // ==========================================================
    // Reset values and the 9-bit size code
    // ==========================================================
    localparam logic [2:0]  RST_CHAR_SIZE = 3'h3;
    localparam logic [11:0] RST_BAUD      = 12'h000;
    localparam logic [2:0]  CHAR_SIZE_9   = 3'h7;

    // ==========================================================
    // Sampling figures
    // ==========================================================
    localparam logic [4:0] SPB_NORMAL   = 5'h10;
    localparam logic [4:0] SPB_DOUBLE   = 5'h08;
    localparam logic [4:0] FIRST_NORMAL = 5'h08;
    localparam logic [4:0] FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] MID_NORMAL   = 5'h09;
    localparam logic [4:0] MID_DOUBLE   = 5'h05;

    typedef enum logic [2:0] {
        RX_IDLE   = 3'b000,
        RX_START  = 3'b001,
        RX_DATA   = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP   = 3'b100
    } uraf_rx_state_e;

endpackage : uraf_pkg

`default_nettype wire

// File: hdl/uraf_rx_filter.sv
// Behaviour
// [RULE_01] Stop bit uses the same three-sample vote; a 0 sets the framing error.
// [RULE_02] Next start edge is accepted right after the stop bit's last vote sample.
// [RULE_03] Sixteen samples per bit normally, eight in double-speed mode.
// [RULE_04] First vote sample is 8 normally, 4 in double speed.
// [RULE_05] Middle vote sample is 9 normally, 5 in double speed.
// [RULE_06] Remote bit rate must lie inside the receiver's tolerated range.
// [RULE_07] Each end should keep its rate error within half the budget.
// [RULE_08] Software picks a baud divisor giving acceptably small error.
// [RULE_09] With address filter on, data-type frames are dropped, never buffered.
// [RULE_10] Transmitter ignores the address filter enable entirely.
// [RULE_11] For 5 to 8 data bits the first stop bit gives frame type.
// [RULE_12] For 9-bit characters the ninth data bit gives frame type.
// [RULE_13] Frame-type one means address, zero means data.
// [RULE_14] Filtering masters use 9-bit frames, ninth bit marks addresses.
// [RULE_15] Address frames under filtering are buffered and flag receive-complete normally.
// [RULE_16] Slave software clears the filter only when its address matches.
// [RULE_17] With filter off, all data frames are buffered normally.
// [RULE_18] After the last data frame, software sets the filter again.
// [RULE_19] Short characters with filtering need two transmitted stop bits.
// [RULE_20] Receiver and transmitter share one character-size setting.
// [RULE_21] Software avoids read-modify-write on the filter enable register.
// [RULE_22] Each bit is the majority of its three centre samples.
// [RULE_23] Start bit with two or more high vote samples is rejected as noise.
// [RULE_24] Only the first stop bit is evaluated; further ones are ignored.
// [RULE_25] Writing one to the transmit-complete bit clears that flag.
// [RULE_26] A dropped data frame leaves all receive status flags unchanged.
`default_nettype none

module uraf_rx_filter (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Serial line
    input  wire logic        RXD,
    output logic             TXD
);
    import uraf_pkg::*;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [3:0] data_bits(input logic [2:0] sel);
        case (sel)
            3'h0: data_bits = 4'h5;
            3'h1: data_bits = 4'h6;
            3'h2: data_bits = 4'h7;
            CHAR_SIZE_9: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction : data_bits

    function automatic logic [8:0] data_mask(input logic [3:0] n);
        data_mask = 9'h1FF >> (4'h9 - n);
    endfunction : data_mask

    // ==========================================================
    // Configuration and status storage
    // ==========================================================
    logic [2:0]  char_size_select_ff;
    logic [1:0]  parity_mode_ff;
    logic        stop_bits_select_ff;
    logic        double_speed_select_ff;
    logic        address_filter_enable_ff;
    logic        rx_enable_ff;
    logic        tx_enable_ff;
    logic        transmit_ninth_bit_ff;
    logic [11:0] baud_divisor_value_ff;
    logic        transmit_complete_flag_ff;
    logic        overrun_ff;
    logic        tx_buf_full_ff;

    logic [3:0]  n_bits;
    logic [8:0]  mask;
    assign n_bits = data_bits(char_size_select_ff);  // [RULE_20]
    assign mask   = data_mask(n_bits);

    // ==========================================================
    // Bus slave: writes take effect at the end of the data phase
    // ==========================================================
    logic       wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic       rd_wait_ff;
    logic [7:0] rd_addr_ff;
    logic [31:0] hrdata_ff;
    logic       take;
    logic       wr_data;
    logic       wr_status;
    logic       wr_ctrl;
    logic       wr_format;
    logic       wr_baud;
    logic       rd_pop;

    assign take      = HSEL && HTRANS[1] && HREADY;
    assign wr_data   = wr_pend_ff && wr_addr_ff == ADDR_DATA;
    assign wr_status = wr_pend_ff && wr_addr_ff == ADDR_STATUS;
    assign wr_ctrl   = wr_pend_ff && wr_addr_ff == ADDR_CTRL;
    assign wr_format = wr_pend_ff && wr_addr_ff == ADDR_FORMAT;
    assign wr_baud   = wr_pend_ff && wr_addr_ff == ADDR_BAUD;

    // One wait state on reads so a write just before is already visible
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rd_wait_ff <= 1'b0;
            rd_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= take && HWRITE;
            rd_wait_ff <= take && !HWRITE;
            if (take) begin
                wr_addr_ff <= HADDR[7:0];
                rd_addr_ff <= HADDR[7:0];
            end
        end
    end

    assign HREADYOUT = !rd_wait_ff;
    assign HRESP     = 1'b0;
    assign HRDATA    = hrdata_ff;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            char_size_select_ff      <= RST_CHAR_SIZE;
            parity_mode_ff           <= 2'h0;
            stop_bits_select_ff      <= 1'b0;
            double_speed_select_ff   <= 1'b0;
            address_filter_enable_ff <= 1'b0;
            rx_enable_ff             <= 1'b0;
            tx_enable_ff             <= 1'b0;
            transmit_ninth_bit_ff    <= 1'b0;
            baud_divisor_value_ff    <= RST_BAUD;
        end else begin
            if (wr_status) begin
                double_speed_select_ff   <= HWDATA[ST_DOUBLE_SPEED];
                address_filter_enable_ff <= HWDATA[ST_ADDR_FILTER];
            end
            if (wr_ctrl) begin
                rx_enable_ff          <= HWDATA[CT_RX_ENABLE];
                tx_enable_ff          <= HWDATA[CT_TX_ENABLE];
                char_size_select_ff[2] <= HWDATA[CT_CHAR_SIZE_HI];
                transmit_ninth_bit_ff <= HWDATA[CT_TX_NINTH];
            end
            if (wr_format) begin
                parity_mode_ff           <= HWDATA[FM_PARITY_LO +: 2];
                stop_bits_select_ff      <= HWDATA[FM_STOP_BITS];
                char_size_select_ff[1:0] <= HWDATA[FM_CHAR_SIZE_LO +: 2];
            end
            if (wr_baud) begin
                baud_divisor_value_ff <= HWDATA[11:0];
            end
        end
    end

    // ==========================================================
    // Receive buffer: two entries of {parity err, framing err, data}
    // ==========================================================
    logic [10:0] fifo_ff [2];
    logic        fifo_wp_ff;
    logic        fifo_rp_ff;
    logic [1:0]  fifo_cnt_ff;
    logic        push;
    logic [10:0] push_word;
    logic [10:0] head;
    logic        rx_complete;

    assign head        = fifo_ff[fifo_rp_ff];
    assign rx_complete = fifo_cnt_ff != 2'h0;
    assign rd_pop      = rd_wait_ff && rd_addr_ff == ADDR_DATA && rx_complete;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            fifo_ff[0]  <= 11'h000;
            fifo_ff[1]  <= 11'h000;
            fifo_wp_ff  <= 1'b0;
            fifo_rp_ff  <= 1'b0;
            fifo_cnt_ff <= 2'h0;
        end else if (!rx_enable_ff) begin
            fifo_wp_ff  <= 1'b0;
            fifo_rp_ff  <= 1'b0;
            fifo_cnt_ff <= 2'h0;
        end else begin
            if (push) begin
                fifo_ff[fifo_wp_ff] <= push_word;
                fifo_wp_ff          <= !fifo_wp_ff;
            end
            if (rd_pop) begin
                fifo_rp_ff <= !fifo_rp_ff;
            end
            fifo_cnt_ff <= fifo_cnt_ff + {1'b0, push} - {1'b0, rd_pop};
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_wait_ff) begin
            hrdata_ff <= 32'h0000_0000;
            case (rd_addr_ff)
                ADDR_DATA: begin
                    hrdata_ff[7:0] <= rx_complete ? head[7:0] : 8'h00;
                end
                ADDR_STATUS: begin
                    hrdata_ff[ST_RX_COMPLETE]  <= rx_complete;
                    hrdata_ff[ST_TX_COMPLETE]  <= transmit_complete_flag_ff;
                    hrdata_ff[ST_TX_EMPTY]     <= !tx_buf_full_ff;
                    hrdata_ff[ST_FRAMING_ERR]  <= rx_complete && head[9];
                    hrdata_ff[ST_OVERRUN]      <= overrun_ff;
                    hrdata_ff[ST_PARITY_ERR]   <= rx_complete && head[10];
                    hrdata_ff[ST_DOUBLE_SPEED] <= double_speed_select_ff;
                    hrdata_ff[ST_ADDR_FILTER]  <= address_filter_enable_ff;
                end
                ADDR_CTRL: begin
                    hrdata_ff[CT_RX_ENABLE]    <= rx_enable_ff;
                    hrdata_ff[CT_TX_ENABLE]    <= tx_enable_ff;
                    hrdata_ff[CT_CHAR_SIZE_HI] <= char_size_select_ff[2];
                    hrdata_ff[CT_RX_NINTH]     <= rx_complete && head[8];
                    hrdata_ff[CT_TX_NINTH]     <= transmit_ninth_bit_ff;
                end
                ADDR_FORMAT: begin
                    hrdata_ff[FM_PARITY_LO +: 2]    <= parity_mode_ff;
                    hrdata_ff[FM_STOP_BITS]         <= stop_bits_select_ff;
                    hrdata_ff[FM_CHAR_SIZE_LO +: 2] <= char_size_select_ff[1:0];
                end
                ADDR_BAUD: begin
                    hrdata_ff[11:0] <= baud_divisor_value_ff;
                end
                default: begin
                    hrdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================================
    // Sample tick: divisor+1 clocks per sample
    // ==========================================================
    logic [11:0] baud_cnt_ff;
    logic        tick;
    assign tick = baud_cnt_ff == 12'h000;  // [RULE_07]

    always_ff @(posedge CLK) begin
        if (RESET) begin
            baud_cnt_ff <= 12'h000;
        end else begin
            baud_cnt_ff <= tick ? baud_divisor_value_ff : baud_cnt_ff - 12'h001;
        end
    end

    // ==========================================================
    // Receiver
    // ==========================================================
    uraf_rx_state_e rx_state_ff;
    logic        rx_prev_ff;
    logic [8:0]  rx_data_ff;
    logic [3:0]  rx_idx_ff;
    logic        rx_par_ff;
    logic        restart;
    logic        vote_done;
    logic        vote_bit;
    logic        frame_type;
    logic        par_err;
    logic        frame_end;

    // Stop vote cycle searches too, else a start at sample 11 is lost at divisor 0
    assign restart = (rx_state_ff == RX_IDLE || frame_end) && tick && rx_prev_ff && !RXD;  // [RULE_02]

    uraf_bit_voter u_voter (
        .CLK          (CLK),
        .RESET        (RESET),
        .RESTART      (restart),
        .TICK         (tick),
        .DOUBLE_SPEED (double_speed_select_ff),
        .RXD          (RXD),
        .VOTE_DONE    (vote_done),
        .VOTE_BIT     (vote_bit)
    );

    assign frame_end  = rx_state_ff == RX_STOP && vote_done;
    // Ninth bit for 9-bit characters, else the first stop bit; one means address
    assign frame_type = (n_bits == 4'h9) ? rx_data_ff[8] : vote_bit;  // [RULE_11] [RULE_12] [RULE_13]
    assign par_err    = parity_mode_ff[1] && ((^(rx_data_ff & mask)) ^ parity_mode_ff[0] ^ rx_par_ff);
    // Dropped data frames never reach the buffer or the flags
    assign push       = frame_end && rx_enable_ff && fifo_cnt_ff != 2'h2
                        && !(address_filter_enable_ff && !frame_type);  // [RULE_09] [RULE_15] [RULE_17] [RULE_26]
    assign push_word  = {par_err, !vote_bit, rx_data_ff};  // [RULE_01]

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rx_prev_ff <= 1'b1;
        end else if (tick) begin
            rx_prev_ff <= RXD;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET || !rx_enable_ff) begin
            rx_state_ff <= RX_IDLE;
            rx_data_ff  <= 9'h000;
            rx_idx_ff   <= 4'h0;
            rx_par_ff   <= 1'b0;
        end else begin
            unique case (rx_state_ff)
                RX_IDLE: begin
                    if (restart) begin
                        rx_state_ff <= RX_START;
                        rx_data_ff  <= 9'h000;
                        rx_idx_ff   <= 4'h0;
                    end
                end
                RX_START: begin
                    if (vote_done) begin
                        rx_state_ff <= vote_bit ? RX_IDLE : RX_DATA;  // [RULE_23]
                    end
                end
                RX_DATA: begin
                    if (vote_done) begin
                        rx_data_ff[rx_idx_ff] <= vote_bit;
                        rx_idx_ff             <= rx_idx_ff + 4'h1;
                        if (rx_idx_ff == n_bits - 4'h1) begin
                            rx_state_ff <= parity_mode_ff[1] ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (vote_done) begin
                        rx_par_ff   <= vote_bit;
                        rx_state_ff <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // Back to edge search at once; further stop bits unseen
                    if (vote_done) begin
                        rx_state_ff <= restart ? RX_START : RX_IDLE;  // [RULE_02] [RULE_24]
                        rx_data_ff  <= 9'h000;
                        rx_idx_ff   <= 4'h0;
                    end
                end
                default: begin
                    rx_state_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // Lost frame when the buffer is full; cleared by the next stored one
    always_ff @(posedge CLK) begin
        if (RESET || !rx_enable_ff) begin
            overrun_ff <= 1'b0;
        end else if (push) begin
            overrun_ff <= 1'b0;
        end else if (frame_end && fifo_cnt_ff == 2'h2 && !(address_filter_enable_ff && !frame_type)) begin
            overrun_ff <= 1'b1;  // [RULE_26]
        end
    end

    // ==========================================================
    // Transmitter: no dependence on the address filter
    // ==========================================================
    logic [8:0]  tx_buf_ff;
    logic [11:0] tx_sh_ff;
    logic [3:0]  tx_left_ff;
    logic [4:0]  tx_tcnt_ff;
    logic        tx_busy_ff;
    logic        txd_ff;
    logic        tx_load;
    logic        tx_bit_end;
    logic        tx_done;
    logic [11:0] tx_frame;
    logic [4:0]  spb;
    logic        tx_par;

    assign spb        = double_speed_select_ff ? SPB_DOUBLE : SPB_NORMAL;  // [RULE_03]
    assign tx_load    = tx_enable_ff && tx_buf_full_ff && !tx_busy_ff;      // [RULE_10]
    assign tx_bit_end = tx_busy_ff && tick && tx_tcnt_ff == spb - 5'h01;
    assign tx_done    = tx_bit_end && tx_left_ff == 4'h1;
    assign tx_par     = (^(tx_buf_ff & mask)) ^ parity_mode_ff[0];

    always_comb begin
        tx_frame = 12'hFFF;
        tx_frame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n_bits)) begin
                tx_frame[i + 1] = tx_buf_ff[i];
            end
        end
        if (parity_mode_ff[1]) begin
            tx_frame[n_bits + 4'h1] = tx_par;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            tx_buf_ff      <= 9'h000;
            tx_buf_full_ff <= 1'b0;
        end else if (wr_data && !tx_buf_full_ff) begin
            tx_buf_ff      <= {transmit_ninth_bit_ff, HWDATA[7:0]};
            tx_buf_full_ff <= 1'b1;
        end else if (tx_load) begin
            tx_buf_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            tx_sh_ff   <= 12'hFFF;
            tx_left_ff <= 4'h0;
            tx_tcnt_ff <= 5'h00;
            tx_busy_ff <= 1'b0;
        end else if (tx_load) begin
            tx_sh_ff   <= tx_frame;
            tx_left_ff <= 4'h2 + n_bits + {3'h0, parity_mode_ff[1]} + {3'h0, stop_bits_select_ff};
            tx_tcnt_ff <= 5'h00;
            tx_busy_ff <= 1'b1;
        end else if (tx_busy_ff && tick) begin
            tx_tcnt_ff <= tx_bit_end ? 5'h00 : tx_tcnt_ff + 5'h01;
            if (tx_bit_end) begin
                tx_sh_ff   <= {1'b1, tx_sh_ff[11:1]};
                tx_left_ff <= tx_left_ff - 4'h1;
                tx_busy_ff <= !tx_done;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            txd_ff <= 1'b1;
        end else begin
            txd_ff <= tx_busy_ff ? tx_sh_ff[0] : 1'b1;
        end
    end
    assign TXD = txd_ff;

    // Completion setting wins over a same-cycle write-one clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            transmit_complete_flag_ff <= 1'b0;
        end else if (tx_done && !tx_buf_full_ff) begin
            transmit_complete_flag_ff <= 1'b1;
        end else if (wr_status && HWDATA[ST_TX_COMPLETE]) begin
            transmit_complete_flag_ff <= 1'b0;  // [RULE_25]
        end
    end

endmodule : uraf_rx_filter

`default_nettype wire

// File: test/tb_uraf_rx_filter.sv
`default_nettype none
module tb_uraf_rx_filter;
    timeunit 1ns;
    timeprecision 100ps;
    import uraf_pkg::*;
    logic        CLK, RESET, HSEL, HWRITE, HREADYOUT, HRESP, RXD, TXD;
    logic [1:0]  HTRANS;
    logic [31:0] HADDR, HWDATA, HRDATA, rv;
    int          fails = 0, num_checks = 0;
    uraf_rx_filter dut (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .RXD(RXD), .TXD(TXD));
    uraf_line_model far (.CLK(CLK), .RXD(RXD));
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    // Ready is looked at before the edge so the edge's own updates cannot race
    task automatic hs;
        logic r;
        do begin
            @(negedge CLK);
            r = HREADYOUT;
            rv = HRDATA;
            @(posedge CLK);
        end while (r !== 1'b1);
    endtask : hs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        HTRANS <= 2'h2;
        HWRITE <= 1'b1;
        HADDR <= {24'h0, a};
        hs;
        HTRANS <= 2'h0;
        HWDATA <= d;
        hs;
    endtask : wr
    task automatic chk(input logic [31:0] e);
        num_checks++;
        if (rv !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, rv, e);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        HTRANS <= 2'h2;
        HWRITE <= 1'b0;
        HADDR <= {24'h0, a};
        hs;
        HTRANS <= 2'h0;
        hs;
        chk(e);
    endtask : rd
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    initial begin
        #50us;
        fails++;
        results;
    end
    initial begin
        RESET = 1'b1;
        HSEL = 1'b1;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HADDR = 32'h0;
        HWDATA = 32'h0;
        repeat (6) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        rd(ADDR_STATUS, 32'h20);
        rd(ADDR_FORMAT, 32'h06);
        rd(8'h14, 32'h0);
        wr(ADDR_BAUD, 32'h0);
        wr(ADDR_CTRL, 32'h10);
        far.send(11'h1A5, 8, 16, 16, 4);
        rd(ADDR_STATUS, 32'hA0);
        rd(ADDR_DATA, 32'hA5);
        far.send(11'h03C, 8, 16, 16, 4);
        rd(ADDR_STATUS, 32'hB0);
        rd(ADDR_DATA, 32'h3C);
        far.send(11'h181, 8, 16, 10, 0);
        far.send(11'h17E, 8, 16, 16, 4);
        rd(ADDR_DATA, 32'h81);
        rd(ADDR_DATA, 32'h7E);
        far.send(11'h001, 0, 7, 1, 200);
        rd(ADDR_STATUS, 32'h20);
        wr(ADDR_STATUS, 32'h02);
        far.send(11'h1C3, 8, 8, 8, 4);
        rd(ADDR_DATA, 32'hC3);
        wr(ADDR_STATUS, 32'h01);
        far.send(11'h011, 8, 16, 16, 4);
        far.send(11'h1AA, 8, 16, 32, 4);
        rd(ADDR_STATUS, 32'hA1);
        rd(ADDR_DATA, 32'hAA);
        wr(ADDR_CTRL, 32'h14);
        far.send(11'h255, 9, 16, 16, 4);
        far.send(11'h333, 9, 16, 16, 4);
        rd(ADDR_CTRL, 32'h16);
        rd(ADDR_DATA, 32'h33);
        wr(ADDR_STATUS, 32'h00);
        far.send(11'h266, 9, 16, 16, 4);
        rd(ADDR_CTRL, 32'h14);
        rd(ADDR_DATA, 32'h66);
        wr(ADDR_STATUS, 32'h01);
        wr(ADDR_CTRL, 32'h1C);
        wr(ADDR_DATA, 32'h55);
        repeat (300) @(posedge CLK);
        rd(ADDR_STATUS, 32'h61);
        wr(ADDR_STATUS, 32'h40);
        rd(ADDR_STATUS, 32'h20);
        results;
    end
endmodule : tb_uraf_rx_filter
bind uraf_rx_filter uraf_rx_filter_monitor mon (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HWRITE(HWRITE),
    .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TXD(TXD), .HTRANS(HTRANS), .HRDATA(HRDATA));
`default_nettype wire

// File: test/uraf_line_model.sv
`default_nettype none
module uraf_line_model (
    input wire logic CLK,
    output var logic RXD
);
    timeunit 1ns;
    timeprecision 100ps;
    initial RXD = 1'b1;
    // Exact bit rate, LSB first; stop level is bit n of f
    task automatic send(input logic [10:0] f, input int n, per, stop, gap);
        RXD <= 1'b0;
        repeat (per) @(posedge CLK);
        for (int i = 0; i < n; i++) begin
            RXD <= f[i];
            repeat (per) @(posedge CLK);
        end
        RXD <= f[n];
        repeat (stop) @(posedge CLK);
        // Gap 0 leaves the line for an at-once next start
        if (gap > 0) begin
            RXD <= 1'b1;
            repeat (gap) @(posedge CLK);
        end
    endtask : send
endmodule : uraf_line_model
`default_nettype wire

// File: test/uraf_rx_filter_monitor.sv
`default_nettype none
module uraf_rx_filter_monitor (
    // Bus and line
    input wire logic        CLK, RESET, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, TXD,
    input wire logic [1:0]  HTRANS,
    input wire logic [31:0] HRDATA
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // ==========
    // Bus steps and line checks
    sequence rd_taken; HSEL && HTRANS[1] && HREADY && !HWRITE; endsequence
    sequence one_wait; !HREADYOUT ##1 HREADYOUT; endsequence
    a_resp_okay: assert property (HRESP == 1'b0) else $error("response not OKAY");
    a_read_wait: assert property (rd_taken |=> one_wait) else $error("read wait wrong");
    a_write_fast: assert property (HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT) else $error("write stalled");
    a_stall_cause: assert property (!HREADYOUT |-> $past(HSEL && HTRANS[1] && HREADY && !HWRITE))
        else $error("stall without read");
    a_rdata_hold: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA)) else $error("read data moved");
    a_idle_after: assert property ($fell(RESET) |-> TXD && HREADYOUT) else $error("not idle after reset");
    a_rdata_clear: assert property ($fell(RESET) |-> HRDATA == 32'h0) else $error("read data not cleared");
    a_start_bit: assert property ($fell(TXD) |-> !TXD [*8]) else $error("start bit short");
endmodule : uraf_rx_filter_monitor
`default_nettype wire
